// ===== verilog/eeprom_read_ack_poll.sv
/*
 Two-wire EEPROM target: select decode, busy polling, address load and reads.
 Assumes scl is the link clock from the master, stopped between frames,
 and sda is open drain, resolved outside from sda_o and sda_oe.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"

//**********************************************************************
// Top block
//**********************************************************************

// Summary of operation
// - Busy device ignores select, no acknowledge
// - Idle device acknowledges matching select again
// - Reads ignore the write inhibit input
// - Counter advances by one per read
// - Read select after address outputs loaded byte
// - Current read outputs counter byte, increments
// - Master acknowledge continues with next address
// - Counter wraps from top to zero
// - No acknowledge ends read, enter standby
// - Array starts erased, every byte all ones
// - Select holds type, chip address, direction
// - Address is two bytes, high first
// - Receiver pulls data low in ninth clock
// - Mismatched select: no acknowledge, standby
module eeprom_read_ack_poll #(
    parameter int unsigned ADDR_W = `EE_ADDR_W,
    parameter logic [3:0] DEV_TYPE = `EE_DEV_TYPE,
    parameter int unsigned PROG_CYCLES =
        (`EE_PROG_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_inhibit_input,
    input wire logic chip_addr_strap0,
    input wire logic chip_addr_strap1,
    input wire logic chip_addr_strap2,
    input wire logic program_start,
    output logic program_busy
);
    import eeprom_pkg::*;

    localparam int unsigned DEPTH = 1 << ADDR_W;

    //******************************************************************
    // Core-clock side: programming busy timer
    //******************************************************************

    prog_busy_if pb ();

    // The write path starts a programming cycle here
    assign pb.start = program_start;
    assign program_busy = pb.busy;

    prog_busy_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .bus(pb)
    );

    //******************************************************************
    // Link side: reset, start detection and input synchronisers
    //******************************************************************

    logic rst_s1_q;
    logic link_rst_q;
    logic start_tog = 1'b0;
    logic start_seen_q;
    logic [4:0] in_s1_q;
    logic [4:0] in_s2_q;
    logic [4:0] in_s3_q;
    logic [4:0] in_q;
    logic busy_s;
    logic wi_s;
    logic [2:0] strap_s;

    // Reset into the link domain; needs scl edges to take effect
    always_ff @(negedge scl) begin
        rst_s1_q <= srst;
        link_rst_q <= rst_s1_q;
    end

    // Start: data falls while clock high; a toggle the link side compares
    always_ff @(negedge sda_i) begin
        if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    // Busy, inhibit and straps cross in; a bit moves once stages 2 and 3 agree
    always_ff @(negedge scl) begin
        in_s1_q <= {program_busy, write_inhibit_input,
                    chip_addr_strap2, chip_addr_strap1, chip_addr_strap0};
        in_s2_q <= in_s1_q;
        in_s3_q <= in_s2_q;
        for (int i = 0; i < 5; i++) begin
            if (in_s2_q[i] == in_s3_q[i]) begin
                in_q[i] <= in_s3_q[i];
            end
        end
    end

    assign busy_s = in_q[4];
    assign wi_s = in_q[3];
    assign strap_s = in_q[2:0];

    //******************************************************************
    // Link side: array, shifter and protocol engine
    //******************************************************************

    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [3:0] cnt_q;
    logic sda_oe_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] addr_hi_q;
    link_state_e state_q;
    link_state_e next_s;
    link_state_e after_q;
    logic ack_ok;
    logic dev_match;
    logic [7:0] rd_byte;

    // Erased array; the write path is not modelled here
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = `EE_ERASED_BYTE;
        end
    end

    assign rd_byte = mem[addr_q];

    // Data is taken on the rising clock edge
    always_ff @(posedge scl) begin
        rx_q <= {rx_q[6:0], sda_i};
    end

    // Select decode: type field, chip address against straps
    assign dev_match = (rx_q[7:4] == DEV_TYPE) && (rx_q[3:1] == strap_s);

    // Ack and follow-on state; only valid while the byte is whole (eighth fall)
    always_comb begin
        ack_ok = 1'b0;
        next_s = LINK_IDLE;
        unique case (state_q)
            LINK_SELECT: begin
                ack_ok = dev_match && !busy_s;
                next_s = rx_q[0] ? LINK_READ : LINK_ADDR_HI;
            end
            LINK_ADDR_HI: begin
                ack_ok = 1'b1;
                next_s = LINK_ADDR_LO;
            end
            LINK_ADDR_LO: begin
                ack_ok = 1'b1;
                next_s = LINK_WDATA;
            end
            LINK_WDATA: begin
                ack_ok = !wi_s;
                next_s = LINK_WDATA;
            end
            LINK_IDLE, LINK_READ: begin
                ack_ok = 1'b0;
            end
        endcase
        if (!ack_ok) begin
            next_s = LINK_IDLE;
        end
    end

    // Protocol engine; the data line only moves on the falling clock edge
    always_ff @(negedge scl) begin
        if (link_rst_q) begin
            state_q <= LINK_IDLE;
            cnt_q <= `EE_CNT_ZERO;
            sda_oe_q <= 1'b0;
            start_seen_q <= start_tog;
            addr_q <= '0;
            addr_hi_q <= 8'h00;
            tx_q <= 8'h00;
            after_q <= LINK_IDLE;
        end else if (start_tog != start_seen_q) begin
            // Start or repeated start: always listen for a select
            start_seen_q <= start_tog;
            state_q <= LINK_SELECT;
            cnt_q <= `EE_CNT_ZERO;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                LINK_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                LINK_READ: begin
                    // Reads go on whatever the inhibit level
                    if (cnt_q < `EE_BIT_LAST) begin
                        cnt_q <= cnt_q + `EE_CNT_ONE;
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                    end else if (cnt_q == `EE_BIT_LAST) begin
                        cnt_q <= `EE_BIT_ACK;
                        sda_oe_q <= 1'b0;
                        addr_q <= addr_q + ADDR_W'(1);
                    end else if (!rx_q[0]) begin
                        cnt_q <= `EE_CNT_ZERO;
                        tx_q <= rd_byte;
                        sda_oe_q <= ~rd_byte[7];
                    end else begin
                        state_q <= LINK_IDLE;
                        cnt_q <= `EE_CNT_ZERO;
                    end
                end
                LINK_SELECT, LINK_ADDR_HI, LINK_ADDR_LO, LINK_WDATA: begin
                    if (cnt_q < `EE_BIT_LAST) begin
                        cnt_q <= cnt_q + `EE_CNT_ONE;
                    end else if (cnt_q == `EE_BIT_LAST) begin
                        cnt_q <= `EE_BIT_ACK;
                        sda_oe_q <= ack_ok;
                        // Kept now: the ack bit shifts into the receiver next
                        after_q <= next_s;
                        if (state_q == LINK_ADDR_HI) begin
                            addr_hi_q <= rx_q;
                        end
                        if (state_q == LINK_ADDR_LO) begin
                            addr_q <= ADDR_W'({addr_hi_q, rx_q});
                        end
                    end else begin
                        cnt_q <= `EE_CNT_ZERO;
                        state_q <= after_q;
                        if (after_q == LINK_READ) begin
                            tx_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
endmodule

// ===== verilog/eeprom_defs.svh
/*
 Named constants of the serial EEPROM read and acknowledge-poll block.
 Assumes it is included by bare name from the design files and the bench.
*/
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Byte address width and framing counts
`define EE_ADDR_W 16
`define EE_BIT_LAST 4'h7
`define EE_BIT_ACK 4'h8
`define EE_CNT_ZERO 4'h0
`define EE_CNT_ONE 4'h1

// Erased array contents
`define EE_ERASED_BYTE 8'hFF

// Device type field; value is arbitrary
`define EE_DEV_TYPE 4'h5

// Core clock and programming busy time
`define EE_CLK_PERIOD_NS 100
`define EE_PROG_TIME_NS 5000000

`endif

// ===== verilog/eeprom_pkg.sv
/*
 Types shared by the EEPROM read and acknowledge-poll design files.
 Assumes eeprom_defs.svh is on the include path.
*/
package eeprom_pkg;

    // Link-side protocol states, one-hot
    typedef enum logic [5:0] {
        LINK_IDLE    = 6'h01,
        LINK_SELECT  = 6'h02,
        LINK_ADDR_HI = 6'h04,
        LINK_ADDR_LO = 6'h08,
        LINK_WDATA   = 6'h10,
        LINK_READ    = 6'h20
    } link_state_e;

endpackage

// ===== verilog/prog_busy_if.sv
/*
 Carrier between the top block and its programming busy timer.
 Assumes both ends sit on the core clock.
*/
`timescale 1ns/1ps
interface prog_busy_if;
    logic start;
    logic busy;
    modport timer (input start, output busy);
    modport user (output start, input busy);
endinterface

// ===== verilog/prog_busy_timer.sv
/*
 Programming busy timer: holds busy for a set number of core clocks.
 Assumes start is a core-clock pulse from the write path.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module prog_busy_timer #(
    parameter int unsigned CYCLES = 50000
) (
    input wire logic clk,
    input wire logic srst,
    prog_busy_if.timer bus
);
    import eeprom_pkg::*;

    logic [31:0] count_q;

    // Down counter; a start while busy is ignored, as the array is locked
    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= 32'h0;
        end else if (bus.start && (count_q == 32'h0)) begin
            count_q <= CYCLES;
        end else if (count_q != 32'h0) begin
            count_q <= count_q - 32'h1;
        end
    end

    assign bus.busy = (count_q != 32'h0);
endmodule

// ===== test/eeprom_read_ack_poll_properties.sv
/*
 Checker on the top ports of the EEPROM read and poll block.
 Assumes it is bound to the top module and sees both clocks.
*/
`timescale 1ns/1ps
module eeprom_read_ack_poll_checker #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic program_start,
    input wire logic program_busy
);
    logic [31:0] busy_cnt_q;
    logic oe_rise_q;
    // Busy length in core clocks, cleared while idle
    always_ff @(posedge clk) begin
        if (srst || !program_busy) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    // Drive enable seen at the rising link edge
    always_ff @(posedge scl) begin
        oe_rise_q <= sda_oe;
    end
    sequence s_start_idle;
        program_start && !program_busy;
    endsequence
    a_busy_starts: assert property (@(posedge clk) disable iff (srst)
        s_start_idle |=> program_busy) else $error("busy did not start");
    a_busy_cause: assert property (@(posedge clk) disable iff (srst)
        !program_busy && !program_start |=> !program_busy) else $error("busy without start");
    a_busy_length: assert property (@(posedge clk) disable iff (srst)
        $fell(program_busy) |-> busy_cnt_q == PROG_CYCLES) else $error("busy length wrong");
    a_busy_bound: assert property (@(posedge clk) disable iff (srst)
        program_busy |-> busy_cnt_q < PROG_CYCLES) else $error("busy too long");
    a_reset_clears: assert property (@(posedge clk)
        srst |=> !program_busy) else $error("busy kept over reset");
    a_sda_o_low: assert property (@(posedge clk) disable iff (srst)
        sda_o == 1'b0) else $error("data output not low");
    a_oe_busy_off: assert property (@(posedge scl) disable iff (srst)
        program_busy && $past(program_busy, 8) |-> !sda_oe) else $error("drive while busy");
    a_oe_changes_low: assert property (@(negedge scl) disable iff (srst)
        sda_oe == oe_rise_q) else $error("data moved with clock high");
endmodule
bind eeprom_read_ack_poll eeprom_read_ack_poll_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clk(clk), .srst(srst), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
    .program_start(program_start), .program_busy(program_busy));

// ===== test/link_master.sv
/*
 Two-wire bus master model: drives the link clock, pulls data low.
 Assumes a pull-up on the data line outside; clock idles high.
*/
`timescale 1ns/1ps
module link_master (
    output logic scl,
    output logic pull_low,
    input wire logic sda
);
    logic [8:0] res;
    event done_ev;
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // Free clocks with data released, for reset and sync
    task automatic clocks(input int n);
        repeat (n) begin
            #16 scl = 1'b0;
            #16 scl = 1'b1;
        end
    endtask
    // Data falls while clock high; also a repeated start
    task automatic start();
        if (scl == 1'b0) begin
            #8 pull_low = 1'b0;
            #8 scl = 1'b1;
        end
        #8 pull_low = 1'b1;
        #8 scl = 1'b0;
    endtask
    task automatic stop();
        #8 pull_low = 1'b1;
        #8 scl = 1'b1;
        #8 pull_low = 1'b0;
        #8;
    endtask
    // Data moves only in the low phase
    task automatic put_bit(input logic b);
        #8 pull_low = ~b;
        #8 scl = 1'b1;
        #16 scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #8 pull_low = 1'b0;
        #8 scl = 1'b1;
        #8 b = sda;
        #8 scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        res = {~a, d};
        -> done_ev;
    endtask
    task automatic rd_byte(input logic ack);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(~ack);
        res = {1'b0, d};
        -> done_ev;
    endtask
endmodule

// ===== test/eeprom_read_ack_poll_tb_top.sv
/*
 Self-checking bench for the EEPROM read and poll block.
 Assumes the master model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module eeprom_read_ack_poll_tb_top;
    import eeprom_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic program_start = 1'b0;
    logic write_inhibit_input = 1'b0;
    logic [2:0] strap = 3'h0;
    logic sda_o, sda_oe, program_busy, scl, pull_low, sda;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [15:0] a;
    int n;
    int err_count = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    // Open drain with pull-up
    assign sda = ~((sda_oe & ~sda_o) | pull_low);
    eeprom_read_ack_poll #(.PROG_CYCLES(20)) DUT (.clk(clk), .srst(srst), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .write_inhibit_input(write_inhibit_input),
        .chip_addr_strap0(strap[0]), .chip_addr_strap1(strap[1]), .chip_addr_strap2(strap[2]),
        .program_start(program_start), .program_busy(program_busy));
    link_master m (.scl(scl), .pull_low(pull_low), .sda(sda));
    function automatic logic [7:0] sel(input logic rd);
        return {`EE_DEV_TYPE, strap, rd};
    endfunction
    // Note the result, then move the byte
    task automatic xw(input logic ack, input logic [7:0] d);
        exp_q.push_back({ack, d});
        m.wr_byte(d);
    endtask
    task automatic xr(input logic ack_m);
        exp_q.push_back({1'b0, `EE_ERASED_BYTE});
        m.rd_byte(ack_m);
    endtask
    // Address counter is not on the pins, so it is looked at inside
    task automatic check_addr(input logic [15:0] want);
        samples_checked++;
        if (DUT.addr_q !== want) begin
            err_count++;
            $display("[FAIL] addr_q expected %h seen %h", want, DUT.addr_q);
        end
    endtask
    task automatic check_busy(input logic want);
        samples_checked++;
        if (program_busy !== want) begin
            err_count++;
            $display("[FAIL] program_busy expected %b seen %b", want, program_busy);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Oldest note against each finished byte
    always @(m.done_ev) begin
        samples_checked++;
        e = exp_q.pop_front();
        if (m.res !== e) begin
            err_count++;
            $display("[FAIL] byte expected %h seen %h", e, m.res);
        end
    end
    initial begin
        void'($urandom(98298));
        strap = 3'($urandom_range(7, 0));
        fork
            m.clocks(14);
            repeat (5) @(negedge clk);
        join
        srst = 1'b0;
        m.clocks(4);
        // Current read after reset, one ack then nack
        m.start();
        xw(1'b1, sel(1'b1));
        xr(1'b1);
        xr(1'b0);
        m.stop();
        check_addr(16'h0002);
        // Random reads, top address first, inhibit either way
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            // Odd passes always inhibited; the top-address pass must wrap
            write_inhibit_input = k[0] | 1'($urandom);
            a = (k == 0) ? 16'hFFFF : 16'($urandom);
            n = (k == 0) ? 3 : $urandom_range(3, 1);
            m.start();
            xw(1'b1, sel(1'b0));
            xw(1'b1, a[15:8]);
            xw(1'b1, a[7:0]);
            m.start();
            xw(1'b1, sel(1'b1));
            repeat (n - 1) xr(1'b1);
            xr(1'b0);
            m.stop();
            check_addr(a + 16'(n));
        end
        // Data byte acked only when not inhibited
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            write_inhibit_input = k[0];
            m.start();
            xw(1'b1, sel(1'b0));
            xw(1'b1, 8'h00);
            xw(1'b1, 8'h00);
            xw(~k[0], 8'($urandom));
            m.stop();
        end
        // Any flipped type or chip address bit gets no answer; the direction bit is left alone
        for (int j = 1; j < 8; j++) begin
            m.start();
            xw(1'b0, sel(1'b1) ^ 8'(1 << j));
            m.stop();
        end
        // Poll during programming, answer after it ends
        @(negedge clk);
        program_start = 1'b1;
        @(negedge clk);
        program_start = 1'b0;
        check_busy(1'b1);
        m.start();
        xw(1'b0, sel(1'b1));
        m.stop();
        for (int t = 0; t < 100 && program_busy !== 1'b0; t++) @(negedge clk);
        check_busy(1'b0);
        m.clocks(4);
        m.start();
        xw(1'b1, sel(1'b1));
        xr(1'b0);
        m.stop();
        check_addr(16'h0001);
        #200;
        samples_checked++;
        if (exp_q.size() != 0) begin
            err_count++;
            $display("[FAIL] pending expected 0 seen %0d", exp_q.size());
        end
        give_verdict();
    end
    // Watchdog well past the expected run
    initial begin
        #300000;
        err_count++;
        give_verdict();
    end
endmodule
